// *** src/owd_receiver.sv ***
// owd_receiver: self-timed one-wire command receiver with stored level.
// assumes an external pull-up on the line; sys_rst_i is the power reset.
//
// Functional notes
// - one command selects one of 32 levels
// - code maps to pseudo-log feedback reference
// - level starts at full-scale code 31
// - level survives line-low shutdown and re-enable
// - power reset returns level to default
// - frame is address byte then data byte
// - act only when address byte matches
// - data: ack request, two sub-address bits, level
// - acknowledge only when acknowledge is requested
// - acknowledge only after full correct matching frame
// - acknowledge pulls low, never drives high
// - decode any rate from 1.7 to 160 kbit/s
// - bytes arrive most significant bit first
// - bit value from high versus low time ratio
// - acknowledge after delay, at most 512 us
`timescale 1ns/10ps
module owd_receiver #(
  parameter logic [7:0] DEV_ADDR  = 8'h5a, // arbitrary value
  parameter int         ACK_CYC   = owd_pkg::ACK_PULSE_CYC,
  parameter int         SHDN_CYC  = owd_pkg::SHDN_CYC
) (
  // clock and power reset
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  // one-wire control pin
  input  wire logic       ctrl_i,
  output logic            ctrl_o,
  output logic            ctrl_oe_n_o,
  // level and status
  output logic [4:0]      level_code_o,
  output logic [7:0]      feedback_reference_o,
  output logic            shutdown_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser; s1 feeds s2 only
  logic line_s1, line_s2, line_s3;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
      line_s3 <= 1'b1;
    end else begin
      line_s1 <= ctrl_i;
      line_s2 <= line_s1;
      line_s3 <= line_s2;
    end
  end
  logic fall, rise;
  assign fall = line_s3 & ~line_s2;
  assign rise = ~line_s3 & line_s2;

  ////////////////////////////////////////////////////////////////////////////
  // shutdown detector: line held low long enough
  logic [owd_pkg::SHDN_W-1:0] shdn_cnt, next_shdn_cnt;
  logic                       shdn, next_shdn;
  always_comb begin
    next_shdn_cnt = '0;
    if (!line_s2) begin
      if (shdn_cnt == owd_pkg::SHDN_W'(SHDN_CYC)) begin
        next_shdn_cnt = shdn_cnt;
      end else begin
        next_shdn_cnt = shdn_cnt + 1'b1;
      end
    end
    next_shdn = (next_shdn_cnt == owd_pkg::SHDN_W'(SHDN_CYC));
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shdn_cnt <= '0;
      shdn     <= 1'b0;
    end else begin
      shdn_cnt <= next_shdn_cnt;
      shdn     <= next_shdn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level code to feedback reference in mV
  function automatic logic [7:0] fb_map(input logic [4:0] code);
    logic [7:0] c8;
    c8 = {3'h0, code};
    if (code == 5'h00) begin
      fb_map = 8'h00;
    end else if (code <= owd_pkg::KNEE1_CODE) begin
      fb_map = owd_pkg::FB_CODE1 + (c8 - 8'h01) * owd_pkg::STEP_FINE;
    end else if (code <= owd_pkg::KNEE2_CODE) begin
      fb_map = owd_pkg::FB_KNEE1 +
               (c8 - {3'h0, owd_pkg::KNEE1_CODE}) * owd_pkg::STEP_MID;
    end else begin
      fb_map = owd_pkg::FB_KNEE2 +
               (c8 - {3'h0, owd_pkg::KNEE2_CODE}) * owd_pkg::STEP_COARSE;
    end
  endfunction : fb_map

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  owd_pkg::owd_state_type      state, next_state;
  logic [owd_pkg::PHASE_W-1:0] low_cnt, next_low_cnt;
  logic [owd_pkg::PHASE_W-1:0] high_cnt, next_high_cnt;
  logic [owd_pkg::ACK_W-1:0]   ack_cnt, next_ack_cnt;
  logic [2:0]                  bit_cnt, next_bit_cnt;
  logic [7:0]                  shreg, next_shreg;
  logic                        byte_idx, next_byte_idx;
  logic                        err, next_err;
  logic                        addr_ok, next_addr_ok;
  logic                        upd, next_upd;
  logic                        drive, next_drive;
  logic [4:0]                  level, next_level;
  logic [7:0]                  fb, next_fb;
  logic                        one_bit, zero_bit;
  logic                        low_sat, high_sat;
  // ratio test needs no notion of bit rate
  assign one_bit  = {1'b0, high_cnt} >= {low_cnt, 1'b0};
  assign zero_bit = {1'b0, low_cnt} >= {high_cnt, 1'b0};
  assign low_sat  = &low_cnt;
  assign high_sat = &high_cnt;
  always_comb begin
    next_state    = state;
    next_low_cnt  = low_sat ? low_cnt : low_cnt + 1'b1;
    next_high_cnt = high_sat ? high_cnt : high_cnt + 1'b1;
    next_ack_cnt  = ack_cnt;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_byte_idx = byte_idx;
    next_err      = err;
    next_addr_ok  = addr_ok;
    next_upd      = 1'b0;
    next_level    = level;
    next_fb       = fb;
    case (state)
      owd_pkg::ST_IDLE: begin
        // a stalled frame between bytes is dropped
        if (high_sat) begin
          next_byte_idx = 1'b0;
        end
        if (fall) begin
          next_state   = owd_pkg::ST_LOW;
          next_low_cnt = '0;
          next_bit_cnt = 3'h0;
          if (!byte_idx) begin
            next_err = 1'b0;
          end
        end
      end
      owd_pkg::ST_LOW: begin
        if (rise) begin
          next_state    = owd_pkg::ST_HIGH;
          next_high_cnt = '0;
        end else if (low_sat) begin
          next_state    = owd_pkg::ST_EOS;
          next_byte_idx = 1'b0;
        end
      end
      owd_pkg::ST_HIGH: begin
        // low time stays frozen while the high phase is timed
        next_low_cnt = low_cnt;
        if (fall) begin
          next_shreg   = {shreg[6:0], one_bit};
          next_err     = err | ~(one_bit | zero_bit);
          next_bit_cnt = bit_cnt + 3'h1;
          next_low_cnt = '0;
          next_state   = owd_pkg::ST_LOW;
          if (bit_cnt == owd_pkg::LAST_BIT) begin
            next_state = owd_pkg::ST_EOS;
            if (!byte_idx) begin
              // address byte decides whether the data byte counts
              next_addr_ok  = (next_shreg == DEV_ADDR) & ~next_err;
              next_byte_idx = next_addr_ok;
            end else begin
              next_byte_idx = 1'b0;
              if (addr_ok && !next_err &&
                  next_shreg[owd_pkg::SUBADDR_HI:owd_pkg::SUBADDR_LO]
                    == 2'h0) begin
                next_upd   = 1'b1;
                next_level = next_shreg[owd_pkg::LEVEL_MSB:0];
                next_fb    = fb_map(next_level);
                if (next_shreg[owd_pkg::ACK_REQ_BIT]) begin
                  next_state   = owd_pkg::ST_ACK_DLY;
                  next_ack_cnt = '0;
                end
              end
            end
          end
        end else if (high_sat) begin
          next_state    = owd_pkg::ST_IDLE;
          next_byte_idx = 1'b0;
        end
      end
      owd_pkg::ST_EOS: begin
        // level test, so a fast release after the closing edge is not lost
        if (line_s2) begin
          next_state    = owd_pkg::ST_IDLE;
          next_high_cnt = '0;
        end
      end
      owd_pkg::ST_ACK_DLY: begin
        next_ack_cnt = ack_cnt + 1'b1;
        if (ack_cnt == owd_pkg::ACK_W'(owd_pkg::ACK_DLY_CYC - 1)) begin
          next_state   = owd_pkg::ST_ACK;
          next_ack_cnt = '0;
        end
      end
      owd_pkg::ST_ACK: begin
        next_ack_cnt = ack_cnt + 1'b1;
        if (ack_cnt == owd_pkg::ACK_W'(ACK_CYC - 1)) begin
          next_state = owd_pkg::ST_EOS;
        end
      end
      default: begin
        next_state = owd_pkg::ST_IDLE;
      end
    endcase
    // shutdown drops a partial frame but keeps the stored level
    if (shdn) begin
      next_state    = owd_pkg::ST_IDLE;
      next_byte_idx = 1'b0;
    end
    next_drive = (next_state == owd_pkg::ST_ACK);
  end

  // only the power reset reaches the level register
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state    <= owd_pkg::ST_IDLE;
      low_cnt  <= '0;
      high_cnt <= '0;
      ack_cnt  <= '0;
      bit_cnt  <= 3'h0;
      shreg    <= 8'h00;
      byte_idx <= 1'b0;
      err      <= 1'b0;
      addr_ok  <= 1'b0;
      upd      <= 1'b0;
      drive    <= 1'b0;
      level    <= owd_pkg::LEVEL_DEFAULT;
      fb       <= owd_pkg::FB_DEFAULT;
    end else begin
      state    <= next_state;
      low_cnt  <= next_low_cnt;
      high_cnt <= next_high_cnt;
      ack_cnt  <= next_ack_cnt;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      byte_idx <= next_byte_idx;
      err      <= next_err;
      addr_ok  <= next_addr_ok;
      upd      <= next_upd;
      drive    <= next_drive;
      level    <= next_level;
      fb       <= next_fb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the line is only ever pulled low
  assign ctrl_o               = 1'b0;
  assign ctrl_oe_n_o          = ~drive;
  assign level_code_o         = level;
  assign feedback_reference_o = fb;
  assign shutdown_o           = shdn;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [owd_pkg::ACK_W:0] drv_len;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drv_len <= '0;
    end else begin
      drv_len <= drive ? drv_len + 1'b1 : '0;
    end
  end

  property p_reset_full;
    $past(sys_rst_i) |-> level == 5'h1f && fb == 8'hc8;
  endproperty
  a_reset_full: assert property (p_reset_full)
    else $error("level not full scale after reset");
  property p_map_points;
    (level == 5'h00 |-> fb == 8'h00) and (level == 5'h01 |-> fb == 8'h05)
    and (level == 5'h0c |-> fb == 8'h26) and (level == 5'h17 |-> fb == 8'h68)
    and (level == 5'h18 |-> fb == 8'h74);
  endproperty
  a_map_points: assert property (p_map_points)
    else $error("feedback reference does not match level code");
  property p_level_cause;
    !$stable(level) |-> $past(next_upd);
  endproperty
  a_level_cause: assert property (p_level_cause)
    else $error("level changed without a valid command");
  property p_upd_valid;
    upd |-> addr_ok && !err && shreg[6:5] == 2'h0 && level == shreg[4:0];
  endproperty
  a_upd_valid: assert property (p_upd_valid)
    else $error("level taken from an invalid command");
  property p_ack_cause;
    $rose(state == owd_pkg::ST_ACK_DLY) |-> upd && shreg[7];
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge armed without a requested valid frame");
  property p_no_ack;
    upd && !shreg[7] |-> ctrl_oe_n_o [*8];
  endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("acknowledge driven without request");
  property p_ack_od;
    !ctrl_oe_n_o |-> state == owd_pkg::ST_ACK && ctrl_o == 1'b0;
  endproperty
  a_ack_od: assert property (p_ack_od)
    else $error("line driven outside acknowledge or driven high");
  property p_ack_len;
    (drv_len <= (owd_pkg::ACK_W + 1)'(ACK_CYC)) and
    ($rose(drive) |-> $past(state == owd_pkg::ST_ACK_DLY));
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("acknowledge too long or without delay");
  property p_bit_one;
    state == owd_pkg::ST_HIGH && fall && one_bit |-> ##1 shreg[0] == 1'b1;
  endproperty
  a_bit_one: assert property (p_bit_one)
    else $error("long high phase not taken as one");
  property p_shdn_hold;
    $rose(shdn) |-> level == $past(level) ##1 $stable(level);
  endproperty
  a_shdn_hold: assert property (p_shdn_hold)
    else $error("shutdown disturbed the stored level");
endmodule : owd_receiver

// *** src/owd_pkg.sv ***
// owd_pkg: constants and types of the one-wire dimming receiver.
// assumes a 50 MHz core clock; the pin is synchronised inside the receiver.
package owd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS  = 20;
  // gap between the closing falling edge and the acknowledge pull-down
  localparam int ACK_DELAY_NS   = 2000;
  localparam int ACK_DLY_CYC    =
    (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest acknowledge pull-down, rounds down
  localparam int ACK_PULSE_US   = 512;
  localparam int ACK_PULSE_CYC  = (ACK_PULSE_US * 1000) / CLK_PERIOD_NS;
  // low time that shuts the device down
  localparam int SHDN_TIME_US   = 2500;
  localparam int SHDN_CYC       = (SHDN_TIME_US * 1000) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int PHASE_W = 16;
  localparam int ACK_W   = 15;
  localparam int SHDN_W  = 17;

  ////////////////////////////////////////////////////////////////////////////
  // data byte layout
  localparam int ACK_REQ_BIT  = 7;
  localparam int SUBADDR_HI   = 6;
  localparam int SUBADDR_LO   = 5;
  localparam int LEVEL_MSB    = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // level code and feedback reference (mV)
  localparam logic [4:0] LEVEL_DEFAULT = 5'h1f;
  localparam logic [7:0] FB_DEFAULT    = 8'hc8;
  localparam logic [4:0] KNEE1_CODE    = 5'h0c;
  localparam logic [4:0] KNEE2_CODE    = 5'h17;
  localparam logic [7:0] FB_CODE1      = 8'h05;
  localparam logic [7:0] FB_KNEE1      = 8'h26;
  localparam logic [7:0] FB_KNEE2      = 8'h68;
  localparam logic [7:0] STEP_FINE     = 8'h03;
  localparam logic [7:0] STEP_MID      = 8'h06;
  localparam logic [7:0] STEP_COARSE   = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // receiver states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_LOW     = 3'h1,
    ST_HIGH    = 3'h2,
    ST_EOS     = 3'h3,
    ST_ACK_DLY = 3'h4,
    ST_ACK     = 3'h5
  } owd_state_type;

endpackage : owd_pkg

// *** verif/owd_host_model.sv ***
// owd_host_model: host side of the one-wire dimming link.
// assumes the bench resolves the wire with a pull-up and the device's pin.
`timescale 1ns/10ps
module owd_host_model (
  // clock
  input  wire logic mclk_i,
  // open-drain line: pull_o high pulls the wire low
  input  wire logic line_i,
  output logic      pull_o
);
  initial pull_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // open-drain only, so acknowledge may be requested
  task automatic hold(input logic pull_low, input int cyc);
    pull_o <= pull_low;
    repeat (cyc) @(posedge mclk_i);
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////
  // bit index bad is sent with equal low and high, which is no valid bit
  task automatic send_frame(input  logic [15:0] frame,
                            input  int          u,
                            input  int          bad,
                            output logic        ack_line);
    hold(1'b0, 110);
    for (int i = 15; i >= 0; i--) begin
      if (i == bad) begin
        hold(1'b1, 2 * u);
        hold(1'b0, 2 * u);
      end else if (frame[i]) begin
        hold(1'b1, u);
        hold(1'b0, 3 * u);
      end else begin
        hold(1'b1, 3 * u);
        hold(1'b0, u);
      end
      if (i == 8) begin
        hold(1'b1, 110);
        hold(1'b0, 110);
      end
    end
    // hold low past the acknowledge delay, then release and read back
    hold(1'b1, 110);
    hold(1'b0, 10);
    @(negedge mclk_i);
    ack_line = line_i;
    @(posedge mclk_i);
    hold(1'b0, 60);
  endtask : send_frame
endmodule : owd_host_model

// *** verif/owd_receiver_tb.sv ***
// owd_receiver_tb: self-checking bench of the one-wire dimming receiver.
// assumes the host model above and short acknowledge/shutdown counts.
`timescale 1ns/10ps
module owd_receiver_tb;
  localparam logic [7:0] ADDR   = 8'h3c; // arbitrary value
  localparam int         ACK_N  = 50;
  localparam int         SHDN_N = 4000;
  localparam int         LIMIT  = 90000;

  logic       mclk_i;
  logic       sys_rst_i;
  logic       pull;
  logic       line;
  logic       ctrl_o;
  logic       ctrl_oe_n_o;
  logic       shutdown_o;
  logic [4:0] level_code_o;
  logic [7:0] fb;
  logic [4:0] cur;
  logic       ack_line;
  int         error_cnt   = 0;
  int         comparisons = 0;
  int         ack_cnt     = 0;
  int         cyc         = 0;

  ////////////////////////////////////////////////////////////////////////////
  // wire: pull-up unless someone pulls low
  assign line = (pull || (ctrl_oe_n_o == 1'b0 && ctrl_o == 1'b0)) ?
                1'b0 : 1'b1;

  owd_receiver #(
    .DEV_ADDR (ADDR),
    .ACK_CYC  (ACK_N),
    .SHDN_CYC (SHDN_N)
  ) i_dut (
    .mclk_i               (mclk_i),
    .sys_rst_i            (sys_rst_i),
    .ctrl_i               (line),
    .ctrl_o               (ctrl_o),
    .ctrl_oe_n_o          (ctrl_oe_n_o),
    .level_code_o         (level_code_o),
    .feedback_reference_o (fb),
    .shutdown_o           (shutdown_o)
  );

  owd_host_model i_host (
    .mclk_i (mclk_i),
    .line_i (line),
    .pull_o (pull)
  );

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  function automatic logic [7:0] fb_exp(input logic [4:0] c);
    int v;
    v = int'(c);
    if (v == 0) return 8'h00;
    if (v <= 12) return 8'(5 + 3 * (v - 1));
    if (v <= 23) return 8'(38 + 6 * (v - 12));
    return 8'(104 + 12 * (v - 23));
  endfunction : fb_exp

  // take says whether the command is expected to land
  task automatic cmd(input logic [7:0] addr, input logic [7:0] data,
                     input int u, input int bad, input logic take);
    logic [4:0] want;
    logic       acked;
    want = take ? data[4:0] : cur;
    acked = take & data[7];
    ack_cnt = 0;
    i_host.send_frame({addr, data}, u, bad, ack_line);
    check("level", level_code_o, want);
    check("feedback", fb, fb_exp(want));
    check("ack line", ack_line, !acked);
    check("ack length", 8'(ack_cnt), acked ? 8'(ACK_N) : 8'h00);
    cur = want;
  endtask : cmd

  task automatic reset_check;
    check("level", level_code_o, 5'h1f);
    check("feedback", fb, 8'hc8);
    check("drive", ctrl_oe_n_o, 1'b1);
    check("shutdown", shutdown_o, 1'b0);
    cur = 5'h1f;
  endtask : reset_check

  ////////////////////////////////////////////////////////////////////////////
  // pulse length and the device never drives high
  always @(posedge mclk_i) begin
    cyc++;
    if (ctrl_oe_n_o === 1'b0) begin
      ack_cnt++;
      check("pin value", ctrl_o, 1'b0);
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    reset_check();
    // every code, acknowledge requested on every other one
    for (int i = 0; i < 32; i++)
      cmd(ADDR, {i[0], 2'b00, 5'(31 - i)}, 5, 16, 1'b1);
    cmd(ADDR ^ 8'h80, 8'h95, 5, 16, 1'b0);
    cmd(ADDR ^ 8'h01, 8'h95, 5, 16, 1'b0);
    cmd(ADDR, 8'hc5, 5, 16, 1'b0);
    cmd(ADDR, 8'ha5, 5, 16, 1'b0);
    cmd(ADDR, 8'h8a, 5, 0, 1'b0);
    cmd(ADDR, 8'h8a, 5, 15, 1'b0);
    cmd(ADDR, 8'h8d, 78, 16, 1'b1);
    cmd(ADDR, 8'h13, 400, 16, 1'b1);
    // one bit of a frame, then a shutdown low
    i_host.hold(1'b1, 5);
    i_host.hold(1'b0, 15);
    i_host.hold(1'b1, SHDN_N + 100);
    check("shutdown", shutdown_o, 1'b1);
    check("level", level_code_o, cur);
    i_host.hold(1'b0, 20);
    check("shutdown", shutdown_o, 1'b0);
    cmd(ADDR, 8'h87, 5, 16, 1'b1);
    // power reset in mid-run
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    reset_check();
    cmd(ADDR, 8'h81, 5, 16, 1'b1);
    tally_and_finish();
  end
endmodule : owd_receiver_tb
